// file: src/drc_timing_regs.vh
// Register offsets, fields, reset values and timing counts of the compressor timing block
`ifndef COMPRESSOR_TIMING_REGS_VH
`define COMPRESSOR_TIMING_REGS_VH
`define CTRL1_OFFSET 7'h44
`define HOLD_OFFSET 7'h45
`define ATK_DEC_OFFSET 7'h46
`define CTRL1_ENABLE_BIT 6
`define CTRL1_HYST_LSB 0
`define CTRL1_RESET 8'h03
`define HOLD_FIELD_LSB 3
`define HOLD_RESET 8'h38
`define HOLD_WMASK 8'h78
`define ATK_DEC_RESET 8'h00
`define HOLD_CODE_OFF 4'h0
`define HOLD_BASE_SHIFT 5
`define HOLD_MAX_CODE_COUNT 18'h28000
`define HOLD_CODE_1101_COUNT 18'h20000
`define HOLD_CODE_1010_COUNT 18'h04000
`define HOLD_CODE_1100_COUNT 18'h02000
`define HOLD_CODE_1011_COUNT 18'h0022c
`define HOLD_CODE_1001_COUNT 18'h02000
`define HOLD_CODE_1110_COUNT 18'h20000
`define ATTACK_BASE_SHIFT 20
`define DECAY_BASE_SHIFT 12
`endif

// file: src/hold_time_decode.v
// Hold-time code to sample-period count decoder
`timescale 1ns/1ps
`default_nettype none
`include "drc_timing_regs.vh"
module hold_time_decode
(
    input wire [3:0] code_i,
    output reg [17:0] count_o
);
    always @*
    begin
        case (code_i)
            4'h0: count_o = 18'h00000;
            4'h1, 4'h2, 4'h3, 4'h4, 4'h5, 4'h6, 4'h7, 4'h8:
                count_o = 18'h00001 << (code_i + 4'h4);
            4'h9: count_o = `HOLD_CODE_1001_COUNT;
            4'ha: count_o = `HOLD_CODE_1010_COUNT;
            4'hb: count_o = `HOLD_CODE_1011_COUNT;
            4'hc: count_o = `HOLD_CODE_1100_COUNT;
            4'hd: count_o = `HOLD_CODE_1101_COUNT;
            4'he: count_o = `HOLD_CODE_1110_COUNT;
            default: count_o = `HOLD_MAX_CODE_COUNT;
        endcase
    end
endmodule // hold_time_decode
`default_nettype wire

// file: src/dynamic_range_compressor_timing.v
// Compressor timing registers and per-sample gain step control
// Contract
// - Hold-time field sits in bits 6..3 of the hold register and resets to 0111 (2048 samples).
// - Hold code 0000 applies no hold interval.
// - Hold codes 0001..0111 give 32..2048 samples by doubling, and 1000 gives 4096.
// - Hold code 1111 gives 163840 samples and 1101 gives 131072.
// - Attack field is bits 7..4 of the third register, reset 0000, 4 dB halving per code.
// - Decay field is bits 3..0 of the third register, reset 0000, step 0.015625 dB over 2^code.
// - Enable bit of the first register turns the compressor on, reset off.
// - Two-bit hysteresis field selects 0..3 dB and resets to 11.
`timescale 1ns/1ps
`default_nettype none
`include "drc_timing_regs.vh"
module dynamic_range_compressor_timing
#(
    parameter GAIN_W = 24
)
(
    input wire clk_i,
    input wire rst_i,
    input wire reg_wr_i,
    input wire [6:0] reg_addr_i,
    input wire [7:0] reg_wdata_i,
    input wire sample_tick_i,
    input wire over_threshold_i,
    output reg [7:0] reg_rdata_o,
    output reg enable_o,
    output reg [1:0] hysteresis_o,
    output reg [GAIN_W-1:0] gain_reduction_o,
    output reg holding_o
);
    // Gain reduction is in dB scaled by 2^20, so 4 dB = 1<<22 and the
    // smallest decay step (2^-6/2^15 dB) is 2^-1 lsb: it truncates to zero.
    reg [7:0] ctrl1;
    reg [7:0] hold_reg;
    reg [7:0] atk_dec;
    reg [17:0] hold_cnt;
    wire [17:0] hold_len;
    wire [3:0] hold_code = hold_reg[6:3];
    wire [GAIN_W-1:0] attack_step;
    wire [GAIN_W-1:0] decay_step;
    reg [GAIN_W-1:0] next_gain;
    hold_time_decode u_hold
    (
        .code_i(hold_code),
        .count_o(hold_len)
    );
    assign attack_step = {{(GAIN_W-1){1'b0}}, 1'b1} << (5'd22 - {1'b0, atk_dec[7:4]});
    assign decay_step = {{(GAIN_W-1){1'b0}}, 1'b1} << (5'd14 - {1'b0, atk_dec[3:0]});
    always @(posedge clk_i)
    begin
        if (rst_i)
        begin
            ctrl1 <= `CTRL1_RESET;
            hold_reg <= `HOLD_RESET;
            atk_dec <= `ATK_DEC_RESET;
        end
        else if (reg_wr_i)
        begin
            if (reg_addr_i == `CTRL1_OFFSET)
                ctrl1 <= reg_wdata_i & 8'h43;
            if (reg_addr_i == `HOLD_OFFSET)
                hold_reg <= reg_wdata_i & `HOLD_WMASK;
            if (reg_addr_i == `ATK_DEC_OFFSET)
                atk_dec <= reg_wdata_i;
        end
    end
    always @*
    begin
        next_gain = gain_reduction_o;
        if (over_threshold_i)
        begin
            if ({1'b0, gain_reduction_o} + {1'b0, attack_step} > {1'b0, {GAIN_W{1'b1}}})
                next_gain = {GAIN_W{1'b1}};
            else
                next_gain = gain_reduction_o + attack_step;
        end
        else if (hold_cnt == 18'h00000)
        begin
            if (gain_reduction_o > decay_step)
                next_gain = gain_reduction_o - decay_step;
            else
                next_gain = {GAIN_W{1'b0}};
        end
    end
    always @(posedge clk_i)
    begin
        if (rst_i)
        begin
            reg_rdata_o <= 8'h00;
            enable_o <= 1'b0;
            hysteresis_o <= 2'b11;
            gain_reduction_o <= {GAIN_W{1'b0}};
            hold_cnt <= 18'h00000;
            holding_o <= 1'b0;
        end
        else
        begin
            enable_o <= ctrl1[`CTRL1_ENABLE_BIT];
            hysteresis_o <= ctrl1[1:0];
            holding_o <= (hold_cnt != 18'h00000);
            case (reg_addr_i)
                `CTRL1_OFFSET: reg_rdata_o <= ctrl1;
                `HOLD_OFFSET: reg_rdata_o <= hold_reg;
                `ATK_DEC_OFFSET: reg_rdata_o <= atk_dec;
                default: reg_rdata_o <= 8'h00;
            endcase
            if (!ctrl1[`CTRL1_ENABLE_BIT])
            begin
                gain_reduction_o <= {GAIN_W{1'b0}};
                hold_cnt <= 18'h00000;
            end
            else if (sample_tick_i)
            begin
                gain_reduction_o <= next_gain;
                if (over_threshold_i)
                    hold_cnt <= hold_len;
                else if (hold_cnt != 18'h00000)
                    hold_cnt <= hold_cnt - 18'h00001;
            end
        end
    end
endmodule // dynamic_range_compressor_timing
`default_nettype wire

// file: testbench/drc_monitor.sv
// Checker for the compressor timing block
`timescale 1ns/1ps
`default_nettype none
module compressor_monitor #(parameter GAIN_W = 24) (input wire logic clk_i, rst_i, reg_wr_i,
    sample_tick_i, over_threshold_i, enable_o, holding_o, input wire logic [6:0] reg_addr_i,
    input wire logic [7:0] reg_wdata_i, reg_rdata_o, input wire logic [1:0] hysteresis_o,
    input wire logic [GAIN_W-1:0] gain_reduction_o);
default clocking @(posedge clk_i); endclocking
default disable iff (rst_i);
sequence s_wr(ad); reg_wr_i && reg_addr_i == ad; endsequence
sequence s_run(o); enable_o && sample_tick_i && over_threshold_i == o ##1 enable_o; endsequence
property p_rst; disable iff (1'b0) rst_i |=> !enable_o && hysteresis_o == 2'h3 && !holding_o;
endproperty
a_rst: assert property (p_rst) else $error("reset state");
property p_en; s_wr(7'h44) |-> ##2 enable_o == $past(reg_wdata_i[6], 2); endproperty
a_en: assert property (p_en) else $error("enable copy");
property p_hys; s_wr(7'h44) |-> ##2 hysteresis_o == $past(reg_wdata_i[1:0], 2); endproperty
a_hys: assert property (p_hys) else $error("hysteresis copy");
// Two low samples so the forced clear has landed
property p_off; !enable_o [*2] |-> gain_reduction_o == 0 && !holding_o; endproperty
a_off: assert property (p_off) else $error("disabled not clear");
property p_idle; enable_o && !sample_tick_i ##1 enable_o |-> $stable(gain_reduction_o);
endproperty
a_idle: assert property (p_idle) else $error("gain moved off tick");
property p_atk; s_run(1'b1) |-> gain_reduction_o >= $past(gain_reduction_o); endproperty
a_atk: assert property (p_atk) else $error("attack fell");
property p_dec; s_run(1'b0) |-> gain_reduction_o <= $past(gain_reduction_o); endproperty
a_dec: assert property (p_dec) else $error("decay rose");
property p_rd; s_wr(7'h45) ##1 reg_addr_i == 7'h45 && !reg_wr_i
    |=> reg_rdata_o == ($past(reg_wdata_i, 2) & 8'h78); endproperty
a_rd: assert property (p_rd) else $error("hold readback");
endmodule // compressor_monitor
bind dynamic_range_compressor_timing compressor_monitor #(.GAIN_W(GAIN_W)) mon (
    .clk_i(clk_i), .rst_i(rst_i), .reg_wr_i(reg_wr_i), .sample_tick_i(sample_tick_i),
    .over_threshold_i(over_threshold_i), .enable_o(enable_o), .holding_o(holding_o),
    .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i), .reg_rdata_o(reg_rdata_o),
    .hysteresis_o(hysteresis_o), .gain_reduction_o(gain_reduction_o));
`default_nettype wire

// file: testbench/testbench.sv
// Bench for the compressor timing block
`timescale 1ns/1ps
`default_nettype none
module testbench;
logic clk_i = 0, rst_i = 1, reg_wr_i = 0, sample_tick_i = 0, over_threshold_i = 0;
logic enable_o, holding_o;
logic [6:0] reg_addr_i = 0;
logic [7:0] reg_wdata_i = 0, reg_rdata_o;
logic [1:0] hysteresis_o, hy;
logic [23:0] gain_reduction_o, g, s;
logic [3:0] a, d;
int err_count = 0, samples_checked = 0, seed = 54, cyc = 0, h, n;
int codes[4] = '{0, 1, 7, 8};
always #4 clk_i = ~clk_i;
dynamic_range_compressor_timing uut (.clk_i(clk_i), .rst_i(rst_i), .reg_wr_i(reg_wr_i),
    .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i), .sample_tick_i(sample_tick_i),
    .over_threshold_i(over_threshold_i), .reg_rdata_o(reg_rdata_o), .enable_o(enable_o),
    .hysteresis_o(hysteresis_o), .gain_reduction_o(gain_reduction_o),
    .holding_o(holding_o));
task automatic cmp(string nm, logic [23:0] e, v);
    samples_checked++;
    if (e !== v)
    begin
        err_count++;
        $display("mismatch %s expected %h seen %h", nm, e, v);
    end
endtask
task automatic wr(logic [6:0] ad, logic [7:0] v);
    @(negedge clk_i) {reg_wr_i, reg_addr_i, reg_wdata_i} = {1'b1, ad, v};
    @(negedge clk_i) reg_wr_i = 0;
endtask
task automatic rd(logic [6:0] ad, logic [7:0] e);
    @(negedge clk_i) reg_addr_i = ad;
    @(negedge clk_i) cmp("rdata", e, reg_rdata_o);
endtask
// One tick every two cycles keeps the longest hold short
task automatic tk(logic o, int k);
    repeat (k)
    begin
        @(negedge clk_i) {sample_tick_i, over_threshold_i} = {1'b1, o};
        @(negedge clk_i) sample_tick_i = 0;
    end
endtask
task automatic summarize;
    if (err_count == 0 && samples_checked > 0)
        $display("Simulation passed");
    else
        $display("Simulation failed");
    $finish;
endtask
always @(posedge clk_i)
begin
    cyc++;
    if (cyc == 40000)
    begin
        err_count++;
        summarize;
    end
end
initial
begin
    repeat (20) @(negedge clk_i);
    rst_i = 0;
    rd(7'h44, 8'h03);
    rd(7'h45, 8'h38);
    rd(7'h46, 8'h00);
    wr(7'h45, 8'hff);
    rd(7'h45, 8'h78);
    foreach (codes[i])
    begin
        h = codes[i];
        n = h ? 32 << (h - 1) : 0;
        a = $unsigned($random(seed)) % 8;
        d = $random(seed);
        hy = $random(seed);
        wr(7'h44, 8'h00);
        wr(7'h45, h << 3);
        wr(7'h46, {a, d});
        wr(7'h44, {2'b01, 4'h0, hy});
        @(negedge clk_i);
        cmp("enable", 1, enable_o);
        cmp("hyst", hy, hysteresis_o);
        g = 24'h1 << (22 - a);
        s = (d > 14) ? 0 : 24'h1 << (14 - d);
        tk(1, 1);
        cmp("gain", g, gain_reduction_o);
        tk(0, n - (h != 0));
        cmp("hold", h != 0, holding_o);
        cmp("gain", g, gain_reduction_o);
        tk(0, 1);
        // The hold flag trails the counter by one clock
        @(negedge clk_i);
        cmp("hold", 0, holding_o);
        tk(0, 1);
        cmp("gain", h ? g - s : g - 2 * s, gain_reduction_o);
    end
    summarize;
end
endmodule // testbench
`default_nettype wire
